// File: verilog/dma_regs.svh
// Constants of the two-channel transfer engine: address map and access timing.
// Assumes a 16-bit data space with byte-wide memories on the same clock.
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH
// Data space map; mapped EEPROM always starts at 0x1000
`define IO_LAST 16'h0FFF
`define EE_BASE 16'h1000
`define EE_LAST 16'h1FFF
// Access latency in cycles, request cycle counted
`define LAT_IO 3'h1
`define LAT_SRAM 3'h2
`define LAT_SRAM_BURST 3'h1
`define LAT_EE 3'h3
`define LAT_EE_BURST 3'h2
// Counter loads for a zero setting
`define BLK_MAX 17'h1_0000
`define REP_MAX 9'h100
// CRC-16 CCITT generator
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF
`endif

// File: verilog/dma_pkg.sv
// Types shared by the transfer engine and its testbench.
// Assumes nothing outside itself.
package dma_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RD = 2'b01, ST_WR = 2'b10, ST_NXT = 2'b11} state_t;
  typedef enum logic [1:0] {AM_FIXED = 2'b00, AM_INC = 2'b01, AM_DEC = 2'b10} addr_mode_t;
  typedef enum logic [1:0] {RL_NONE = 2'b00, RL_BURST = 2'b01, RL_BLOCK = 2'b10, RL_TRANS = 2'b11} reload_t;
  typedef enum logic [1:0] {TR_SW = 2'b00, TR_PERIPH = 2'b01, TR_EVENT = 2'b10} trig_t;
  typedef enum logic [1:0] {RG_IO = 2'b00, RG_EE = 2'b01, RG_SRAM = 2'b10} region_t;
endpackage : dma_pkg

// File: verilog/dma_link_if.sv
// Carrier between the engine, its channel arbiter and its CRC generator.
// Assumes all three share one clock, reset and clock enable.
`timescale 1ns/1ps
interface dma_link_if (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i
);
  logic [1:0] req;
  logic prio_rr;
  logic take;
  logic gnt_vld;
  logic gnt_id;
  logic crc_vld;
  logic [7:0] crc_byte;
  logic crc_clr;
  logic [15:0] crc_val;
  modport eng (input clk_i, sys_rst_i, ce_i, gnt_vld, gnt_id, crc_val,
               output req, prio_rr, take, crc_vld, crc_byte, crc_clr);
  modport arb (input clk_i, sys_rst_i, ce_i, req, prio_rr, take, output gnt_vld, gnt_id);
  modport crc (input clk_i, sys_rst_i, ce_i, crc_vld, crc_byte, crc_clr, output crc_val);
endinterface : dma_link_if

// File: verilog/dma_arb.sv
// Channel arbiter: picks which armed channel runs its next burst.
// Assumes the engine pulses take only between bursts.
`timescale 1ns/1ps
module dma_arb (
  dma_link_if.arb lk
);
  logic last_r, last_nxt;

  // Fixed priority to channel 0, or alternate when round robin is chosen
  always_comb begin
    lk.gnt_vld = |lk.req;
    if (&lk.req) begin
      lk.gnt_id = lk.prio_rr ? ~last_r : 1'b0;
    end else begin
      lk.gnt_id = lk.req[1];
    end
    last_nxt = lk.take ? lk.gnt_id : last_r;
  end

  always_ff @(posedge lk.clk_i) begin
    if (lk.sys_rst_i) begin
      last_r <= 1'b1;
    end else if (lk.ce_i) begin
      last_r <= last_nxt;
    end
  end

  property p_fixed_prio;
    @(posedge lk.clk_i) disable iff (lk.sys_rst_i)
    (&lk.req && !lk.prio_rr) |-> (lk.gnt_vld && !lk.gnt_id);
  endproperty
  a_fixed_prio: assert property (p_fixed_prio) else $error("fixed priority not honoured");
endmodule : dma_arb

// File: verilog/dma_crc.sv
// CRC-16 CCITT over the bytes that the engine moves.
// Assumes at most one byte is offered per cycle.
`timescale 1ns/1ps
`include "dma_regs.svh"
module dma_crc (
  dma_link_if.crc lk
);
  logic [15:0] crc_r, crc_nxt;

  // Bitwise update, MSB first; one byte per cycle is plenty here
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int b = 7; b >= 0; b--) begin
      x = (x[15] ^ d[b]) ? ((x << 1) ^ `CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : crc_byte

  always_comb begin
    crc_nxt = crc_r;
    if (lk.crc_clr) begin
      crc_nxt = `CRC_INIT;
    end else if (lk.crc_vld) begin
      crc_nxt = crc_byte(crc_r, lk.crc_byte);
    end
  end

  always_ff @(posedge lk.clk_i) begin
    if (lk.sys_rst_i) begin
      crc_r <= `CRC_INIT;
    end else if (lk.ce_i) begin
      crc_r <= crc_nxt;
    end
  end

  assign lk.crc_val = crc_r;
endmodule : dma_crc

// File: verilog/dma_engine.sv
// Two-channel transfer engine moving bytes between memory sets in bursts.
// Assumes memories and peripherals on clk_i; rd_data_i valid at the edge the
// latency table names; triggers come from same-clock logic.
// How it works
// - Two channels, own trigger, interrupt, addressing
// - Bursts of 1, 2, 4 or 8 bytes
// - Block size 1 byte to 64KB
// - Repeat counter re-runs block, up to 16MB
// - Per-side address fixed, up or down
// - Reload address after burst, block or transaction
// - Start on software, peripheral or event
// - Each channel keeps its own settings
// - Done and error interrupts, separately enabled
// - Interlinked channels start each other alternately
// - Memory and peripheral in any combination
// - Moved bytes optionally feed the CRC
// - Mapped EEPROM readable, starting at 0x1000
// - EEPROM reachable only when mapping enabled
// - SRAM write 1, read 2, burst 1/cycle
// - EEPROM load 1, read 3, burst every 2nd
// - I/O access takes one cycle
// - Separate read and write ports, never used in the same cycle
`timescale 1ns/1ps
`include "dma_regs.svh"
module dma_engine (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [1:0] ch_en_i,
  input wire logic [1:0] sw_req_i,
  input wire logic [1:0] periph_req_i,
  input wire logic [1:0] event_i,
  input wire logic [1:0][1:0] trig_sel_i,
  input wire logic [1:0][15:0] src_addr_i,
  input wire logic [1:0][15:0] dst_addr_i,
  input wire logic [1:0][1:0] src_mode_i,
  input wire logic [1:0][1:0] dst_mode_i,
  input wire logic [1:0][1:0] src_reload_i,
  input wire logic [1:0][1:0] dst_reload_i,
  input wire logic [1:0][1:0] burst_sel_i,
  input wire logic [1:0][15:0] block_size_i,
  input wire logic [1:0][7:0] repeat_i,
  input wire logic [1:0] done_ie_i,
  input wire logic [1:0] err_ie_i,
  input wire logic [1:0] crc_en_i,
  input wire logic link_en_i,
  input wire logic prio_rr_i,
  input wire logic ee_map_en_i,
  input wire logic crc_clr_i,
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic wr_req_o,
  output logic [15:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [15:0] crc_o,
  output logic [1:0] busy_o,
  output logic [1:0] done_irq_o,
  output logic [1:0] err_irq_o,
  output logic active_ch_o
);
  dma_link_if lk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i));
  dma_arb u_arb (.lk(lk));
  dma_crc u_crc (.lk(lk));

  dma_pkg::state_t st_r, st_nxt;
  logic [15:0] saddr_r, saddr_nxt, daddr_r, daddr_nxt;
  logic [3:0] n_r, n_nxt, idx_r, idx_nxt, blen;
  logic [2:0] wait_r, wait_nxt;
  logic iss_r, iss_nxt, first_r, first_nxt, cur_r, cur_nxt;
  logic [7:0][7:0] buf_r, buf_nxt;
  logic take, kill, crc_vld, bad, last_byte;
  logic [1:0][15:0] csrc_a, cdst_a;
  logic [1:0][16:0] crem_a;
  logic [1:0][8:0] crep_a;
  logic [1:0] armed_a, done_a, err_a;
  logic wb, blk_end, tr_end;
  logic [16:0] rem_left, rem_new;
  logic [8:0] rep_new;
  logic [15:0] src_new, dst_new;

  // Address map decode; EEPROM window only means anything when mapped
  function automatic dma_pkg::region_t region(input logic [15:0] a);
    if (a <= `IO_LAST) begin
      return dma_pkg::RG_IO;
    end else if (a <= `EE_LAST) begin
      return dma_pkg::RG_EE;
    end else begin
      return dma_pkg::RG_SRAM;
    end
  endfunction : region

  // Cycles from request to captured byte, first byte of a burst or a later one
  function automatic logic [2:0] lat(input logic first, input logic [15:0] a);
    case (region(a))
      dma_pkg::RG_IO: return `LAT_IO;
      dma_pkg::RG_EE: return first ? `LAT_EE : `LAT_EE_BURST;
      default: return first ? `LAT_SRAM : `LAT_SRAM_BURST;
    endcase
  endfunction : lat

  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
    case (dma_pkg::addr_mode_t'(m))
      dma_pkg::AM_INC: return a + 16'h0001;
      dma_pkg::AM_DEC: return a - 16'h0001;
      default: return a;
    endcase
  endfunction : step

  function automatic logic reload(input logic [1:0] m, input logic be, input logic te);
    case (dma_pkg::reload_t'(m))
      dma_pkg::RL_BURST: return 1'b1;
      dma_pkg::RL_BLOCK: return be;
      dma_pkg::RL_TRANS: return te;
      default: return 1'b0;
    endcase
  endfunction : reload

  // Arbiter and CRC hookup; only armed, enabled channels compete
  assign lk.req = armed_a & ch_en_i;
  assign lk.prio_rr = prio_rr_i;
  assign lk.take = take;
  assign lk.crc_vld = crc_vld;
  assign lk.crc_byte = rd_data_i;
  assign lk.crc_clr = crc_clr_i;
  assign last_byte = (idx_r == n_r - 4'h1);
  assign blen = 4'h1 << burst_sel_i[lk.gnt_id];
  assign bad = !ee_map_en_i && (region(csrc_a[lk.gnt_id]) == dma_pkg::RG_EE ||
                                region(cdst_a[lk.gnt_id]) == dma_pkg::RG_EE);

  // Burst sequencer: read the whole burst into the buffer, then write it out
  always_comb begin
    st_nxt = st_r;
    saddr_nxt = saddr_r;
    daddr_nxt = daddr_r;
    n_nxt = n_r;
    idx_nxt = idx_r;
    wait_nxt = wait_r;
    iss_nxt = 1'b0;
    first_nxt = first_r;
    cur_nxt = cur_r;
    buf_nxt = buf_r;
    take = 1'b0;
    kill = 1'b0;
    crc_vld = 1'b0;
    case (st_r)
      dma_pkg::ST_IDLE: begin
        if (lk.gnt_vld) begin
          take = 1'b1;
          cur_nxt = lk.gnt_id;
          saddr_nxt = csrc_a[lk.gnt_id];
          daddr_nxt = cdst_a[lk.gnt_id];
          if (bad) begin
            kill = 1'b1;
          end else begin
            st_nxt = dma_pkg::ST_RD;
            // Last burst of a block is cut to what the block has left
            n_nxt = (crem_a[lk.gnt_id] < {13'h0000, blen}) ? crem_a[lk.gnt_id][3:0] : blen;
            idx_nxt = 4'h0;
            wait_nxt = lat(1'b1, csrc_a[lk.gnt_id]) - 3'h1;
            iss_nxt = 1'b1;
            first_nxt = 1'b1;
          end
        end
      end
      dma_pkg::ST_RD: begin
        if (wait_r == 3'h0) begin
          buf_nxt[idx_r[2:0]] = rd_data_i;
          saddr_nxt = step(saddr_r, src_mode_i[cur_r]);
          crc_vld = crc_en_i[cur_r];
          if (last_byte) begin
            st_nxt = dma_pkg::ST_WR;
            idx_nxt = 4'h0;
          end else begin
            idx_nxt = idx_r + 4'h1;
            wait_nxt = lat(1'b0, saddr_nxt) - 3'h1;
            iss_nxt = 1'b1;
            first_nxt = 1'b0;
          end
        end else begin
          wait_nxt = wait_r - 3'h1;
        end
      end
      dma_pkg::ST_WR: begin
        // Every write, to any set, is a single cycle
        daddr_nxt = step(daddr_r, dst_mode_i[cur_r]);
        if (last_byte) begin
          st_nxt = dma_pkg::ST_NXT;
        end else begin
          idx_nxt = idx_r + 4'h1;
        end
      end
      default: begin
        st_nxt = dma_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= dma_pkg::ST_IDLE;
      saddr_r <= 16'h0000;
      daddr_r <= 16'h0000;
      n_r <= 4'h1;
      idx_r <= 4'h0;
      wait_r <= 3'h0;
      iss_r <= 1'b0;
      first_r <= 1'b0;
      cur_r <= 1'b0;
      buf_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      saddr_r <= saddr_nxt;
      daddr_r <= daddr_nxt;
      n_r <= n_nxt;
      idx_r <= idx_nxt;
      wait_r <= wait_nxt;
      iss_r <= iss_nxt;
      first_r <= first_nxt;
      cur_r <= cur_nxt;
      buf_r <= buf_nxt;
    end
  end

  // End of burst bookkeeping for the channel that just ran
  always_comb begin
    wb = (st_r == dma_pkg::ST_NXT);
    rem_left = crem_a[cur_r] - {13'h0000, n_r};
    blk_end = (rem_left == 17'h0_0000);
    tr_end = blk_end && (crep_a[cur_r] == 9'h001);
    if (!blk_end) begin
      rem_new = rem_left;
      rep_new = crep_a[cur_r];
    end else begin
      rem_new = (block_size_i[cur_r] == 16'h0000) ? `BLK_MAX : {1'b0, block_size_i[cur_r]};
      if (tr_end) begin
        rep_new = (repeat_i[cur_r] == 8'h00) ? `REP_MAX : {1'b0, repeat_i[cur_r]};
      end else begin
        rep_new = crep_a[cur_r] - 9'h001;
      end
    end
    src_new = reload(src_reload_i[cur_r], blk_end, tr_end) ? src_addr_i[cur_r] : saddr_r;
    dst_new = reload(dst_reload_i[cur_r], blk_end, tr_end) ? dst_addr_i[cur_r] : daddr_r;
  end

  // Per-channel context; a trigger in the cycle a run ends re-arms the channel
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [15:0] src_r, src_nxt, dst_r, dst_nxt;
    logic [16:0] rem_r, rem_nxt;
    logic [8:0] rep_r, rep_nxt;
    logic arm_r, arm_nxt, en_r, done_r, done_nxt, err_r, err_nxt, trig;
    always_comb begin
      case (dma_pkg::trig_t'(trig_sel_i[i]))
        dma_pkg::TR_SW: trig = sw_req_i[i];
        dma_pkg::TR_PERIPH: trig = periph_req_i[i];
        dma_pkg::TR_EVENT: trig = event_i[i];
        default: trig = 1'b0;
      endcase
      src_nxt = src_r;
      dst_nxt = dst_r;
      rem_nxt = rem_r;
      rep_nxt = rep_r;
      arm_nxt = arm_r;
      done_nxt = 1'b0;
      err_nxt = 1'b0;
      if (ch_en_i[i] && !en_r) begin
        src_nxt = src_addr_i[i];
        dst_nxt = dst_addr_i[i];
        rem_nxt = (block_size_i[i] == 16'h0000) ? `BLK_MAX : {1'b0, block_size_i[i]};
        rep_nxt = (repeat_i[i] == 8'h00) ? `REP_MAX : {1'b0, repeat_i[i]};
      end
      if (wb && cur_r == 1'(i)) begin
        src_nxt = src_new;
        dst_nxt = dst_new;
        rem_nxt = rem_new;
        rep_nxt = rep_new;
        if (tr_end) begin
          arm_nxt = 1'b0;
          done_nxt = done_ie_i[i];
        end
      end
      if (kill && lk.gnt_id == 1'(i)) begin
        arm_nxt = 1'b0;
        err_nxt = err_ie_i[i];
      end
      if (link_en_i && wb && tr_end && cur_r != 1'(i)) begin
        arm_nxt = 1'b1;
      end
      if (trig) begin
        arm_nxt = 1'b1;
      end
      if (!ch_en_i[i]) begin
        arm_nxt = 1'b0;
      end
    end
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        src_r <= 16'h0000;
        dst_r <= 16'h0000;
        rem_r <= `BLK_MAX;
        rep_r <= 9'h001;
        arm_r <= 1'b0;
        en_r <= 1'b0;
        done_r <= 1'b0;
        err_r <= 1'b0;
      end else if (ce_i) begin
        src_r <= src_nxt;
        dst_r <= dst_nxt;
        rem_r <= rem_nxt;
        rep_r <= rep_nxt;
        arm_r <= arm_nxt;
        en_r <= ch_en_i[i];
        done_r <= done_nxt;
        err_r <= err_nxt;
      end
    end
    assign csrc_a[i] = src_r;
    assign cdst_a[i] = dst_r;
    assign crem_a[i] = rem_r;
    assign crep_a[i] = rep_r;
    assign armed_a[i] = arm_r;
    assign done_a[i] = done_r;
    assign err_a[i] = err_r;
  end

  // Read and write sides are separate ports, but a burst is read whole before it is written, so they are never active at once
  assign rd_req_o = (st_r == dma_pkg::ST_RD) && iss_r;
  assign rd_addr_o = saddr_r;
  assign wr_req_o = (st_r == dma_pkg::ST_WR);
  assign wr_addr_o = daddr_r;
  assign wr_data_o = buf_r[idx_r[2:0]];
  assign crc_o = lk.crc_val;
  assign busy_o = armed_a;
  assign done_irq_o = done_a;
  assign err_irq_o = err_a;
  assign active_ch_o = cur_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i);

  sequence s_ee_wait;
    !rd_req_o [*2] ##1 rd_req_o;
  endsequence
  sequence s_ee_gap;
    !rd_req_o ##1 rd_req_o;
  endsequence
  property p_sram_first;
    (rd_req_o && first_r && region(rd_addr_o) == dma_pkg::RG_SRAM) |=> !rd_req_o;
  endproperty
  a_sram_first: assert property (p_sram_first) else $error("SRAM first read too short");
  property p_sram_burst;
    (rd_req_o && !first_r && !last_byte && region(rd_addr_o) == dma_pkg::RG_SRAM) |=> rd_req_o;
  endproperty
  a_sram_burst: assert property (p_sram_burst) else $error("SRAM burst not one byte per cycle");
  property p_ee_first;
    (rd_req_o && first_r && !last_byte && region(rd_addr_o) == dma_pkg::RG_EE &&
     region(step(rd_addr_o, src_mode_i[cur_r])) == dma_pkg::RG_EE) |=> s_ee_wait;
  endproperty
  a_ee_first: assert property (p_ee_first) else $error("EEPROM first read not three cycles");
  property p_ee_burst;
    (rd_req_o && !first_r && !last_byte && region(rd_addr_o) == dma_pkg::RG_EE &&
     region(step(rd_addr_o, src_mode_i[cur_r])) == dma_pkg::RG_EE) |=> s_ee_gap;
  endproperty
  a_ee_burst: assert property (p_ee_burst) else $error("EEPROM burst not every second cycle");
  property p_io_one;
    (rd_req_o && !last_byte && region(rd_addr_o) == dma_pkg::RG_IO &&
     region(step(rd_addr_o, src_mode_i[cur_r])) == dma_pkg::RG_IO) |=> rd_req_o;
  endproperty
  a_io_one: assert property (p_io_one) else $error("I/O read not single cycle");
  property p_ee_map;
    ((rd_req_o && region(rd_addr_o) == dma_pkg::RG_EE) ||
     (wr_req_o && region(wr_addr_o) == dma_pkg::RG_EE)) |-> ee_map_en_i;
  endproperty
  a_ee_map: assert property (p_ee_map) else $error("EEPROM touched while unmapped");
  property p_dst_inc;
    (wr_req_o && !last_byte && dst_mode_i[cur_r] == 2'b01) |=> (wr_addr_o == $past(wr_addr_o) + 16'h0001);
  endproperty
  a_dst_inc: assert property (p_dst_inc) else $error("destination did not count up");
  property p_burst_len;
    (take && !kill) |=> (n_r != 4'h0 && n_r <= (4'h1 << burst_sel_i[cur_r]));
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length out of range");
  property p_link;
    (wb && tr_end && !cur_r && link_en_i && ch_en_i[1]) |=> armed_a[1];
  endproperty
  a_link: assert property (p_link) else $error("linked channel not started");
  property p_done_irq;
    (wb && tr_end && done_ie_i[cur_r]) |=> (done_irq_o != 2'b00);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done interrupt missing");
endmodule : dma_engine

// File: verif/dma_mem_model.sv
// Partner model: SRAM, mapped EEPROM and I/O sets behind the engine's ports.
// Assumes the engine's clock and reset; writes complete in their own cycle.
`timescale 1ns/1ps
`include "dma_regs.svh"
module dma_mem_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [2:0] wait_r;
  logic [2:0] wait_nxt;
  logic [2:0] lat;
  logic cap_r;
  logic cap_nxt;
  logic [7:0] mem_val;

  // Byte content is a pure function of the address
  assign mem_val = rd_addr_i[7:0] ^ rd_addr_i[15:8] ^ 8'h5A;

  // Latency by set; a read right after a capture continues a burst
  always_comb begin
    if (rd_addr_i <= `IO_LAST) lat = 3'h1;
    else if (rd_addr_i <= `EE_LAST) lat = cap_r ? 3'h2 : 3'h3;
    else lat = cap_r ? 3'h1 : 3'h2;
    wait_nxt = (wait_r != 3'h0) ? wait_r - 3'h1 : 3'h0;
    cap_nxt = (wait_r == 3'h1) || (rd_req_i && lat == 3'h1);
    if (rd_req_i && lat != 3'h1) wait_nxt = lat - 3'h1;
    // Inverse outside the valid cycle, so early or late capture shows up
    rd_data_o = cap_nxt ? mem_val : ~mem_val;
  end

  // Writes need no answer; the engine never reads and writes in one cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_r <= 3'h0;
      cap_r <= 1'h0;
    end else begin
      wait_r <= wait_nxt;
      cap_r <= cap_nxt;
    end
  end
endmodule : dma_mem_model

// File: verif/two_channel_dma_engine_tb_top.sv
// Self-checking bench for the two-channel transfer engine.
// Assumes dma_mem_model answers reads; writes are checked here.
`timescale 1ns/1ps
`include "dma_regs.svh"
module two_channel_dma_engine_tb_top;
  typedef struct {
    logic c;
    logic [1:0] trig, sm, dm, sr, dr, bs;
    logic [15:0] src, dst, blk;
    logic [7:0] rep;
    logic crc;
  } row_t;
  logic clk_i, sys_rst_i, ce_i, link_en_i, prio_rr_i, ee_map_en_i, crc_clr_i;
  logic [1:0] ch_en_i, sw_req_i, periph_req_i, event_i, done_ie_i, err_ie_i, crc_en_i;
  logic [1:0][1:0] trig_sel_i, src_mode_i, dst_mode_i, src_reload_i, dst_reload_i, burst_sel_i;
  logic [1:0][15:0] src_addr_i, dst_addr_i, block_size_i;
  logic [1:0][7:0] repeat_i;
  logic [7:0] rd_data_i, wr_data_o;
  logic [15:0] rd_addr_o, wr_addr_o, crc_o, exp_crc;
  logic rd_req_o, wr_req_o, active_ch_o;
  logic [1:0] busy_o, done_irq_o, err_irq_o;
  int n_fail = 0;
  int tests_run = 0;
  int done_cnt [2], err_cnt [2], exp_done [2], exp_err [2];
  logic [15:0] exp_a [$];
  logic [7:0] exp_d [$];
  row_t rows [5];
  row_t er, q;

  dma_engine dut (.clk_i, .sys_rst_i, .ce_i, .ch_en_i, .sw_req_i, .periph_req_i, .event_i, .trig_sel_i,
    .src_addr_i, .dst_addr_i, .src_mode_i, .dst_mode_i, .src_reload_i, .dst_reload_i, .burst_sel_i,
    .block_size_i, .repeat_i, .done_ie_i, .err_ie_i, .crc_en_i, .link_en_i, .prio_rr_i, .ee_map_en_i,
    .crc_clr_i, .rd_req_o, .rd_addr_o, .rd_data_i, .wr_req_o, .wr_addr_o, .wr_data_o, .crc_o, .busy_o,
    .done_irq_o, .err_irq_o, .active_ch_o);
  dma_mem_model mem (.clk_i, .sys_rst_i, .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i));

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    chk_word({8'h00, g}, {8'h00, e});
  endtask : chk_byte

  task automatic chk_flag(input logic [1:0] g, input logic [1:0] e);
    chk_word({14'h0000, g}, {14'h0000, e});
  endtask : chk_flag

  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mem_val

  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
    return (m == dma_pkg::AM_INC) ? a + 16'h0001 : (m == dma_pkg::AM_DEC) ? a - 16'h0001 : a;
  endfunction : step

  // MSB-first CRC over one byte
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'h0} ^ ((c[15] ^ b[i]) ? `CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_upd

  // Expected writes; transaction-end reload is covered by the context reload on enable
  task automatic build(input row_t r);
    logic [15:0] s, d;
    int left, n;
    s = r.src;
    d = r.dst;
    for (int b = 0; b < r.rep; b++) begin
      for (left = r.blk; left > 0; left -= n) begin
        n = (left < (1 << r.bs)) ? left : (1 << r.bs);
        for (int k = 0; k < n; k++) begin
          exp_a.push_back(d);
          exp_d.push_back(mem_val(s));
          if (r.crc) exp_crc = crc_upd(exp_crc, mem_val(s));
          s = step(s, r.sm);
          d = step(d, r.dm);
        end
        if (r.sr == dma_pkg::RL_BURST) s = r.src;
        if (r.dr == dma_pkg::RL_BURST) d = r.dst;
      end
      if (r.sr == dma_pkg::RL_BLOCK) s = r.src;
      if (r.dr == dma_pkg::RL_BLOCK) d = r.dst;
    end
  endtask : build

  // Program one channel, clear the CRC, then raise its enable
  task automatic cfg(input row_t r);
    @(posedge clk_i);
    trig_sel_i[r.c] <= r.trig;
    src_addr_i[r.c] <= r.src;
    dst_addr_i[r.c] <= r.dst;
    src_mode_i[r.c] <= r.sm;
    dst_mode_i[r.c] <= r.dm;
    src_reload_i[r.c] <= r.sr;
    dst_reload_i[r.c] <= r.dr;
    burst_sel_i[r.c] <= r.bs;
    block_size_i[r.c] <= r.blk;
    repeat_i[r.c] <= r.rep;
    crc_en_i[r.c] <= r.crc;
    ch_en_i[r.c] <= 1'h0;
    crc_clr_i <= 1'h1;
    exp_crc = `CRC_INIT;
    @(posedge clk_i);
    crc_clr_i <= 1'h0;
    ch_en_i[r.c] <= 1'h1;
  endtask : cfg

  // One-cycle pulse on one kind of trigger line for the masked channels
  task automatic fire(input logic [1:0] m, input logic [1:0] t);
    @(posedge clk_i);
    sw_req_i <= (t == dma_pkg::TR_SW) ? m : 2'h0;
    periph_req_i <= (t == dma_pkg::TR_PERIPH) ? m : 2'h0;
    event_i <= (t == dma_pkg::TR_EVENT) ? m : 2'h0;
    @(posedge clk_i);
    sw_req_i <= 2'h0;
    periph_req_i <= 2'h0;
    event_i <= 2'h0;
  endtask : fire

  task automatic wait_idle(input logic c);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(negedge clk_i);
      if (busy_o[c] === 1'h0) break;
    end
    if (i == 4000) begin
      n_fail++;
      summarize();
    end else begin
      // Let the monitor count the closing pulse before the counters are read
      @(negedge clk_i);
      @(posedge clk_i);
    end
  endtask : wait_idle

  task automatic end_chk();
    chk_word(16'(exp_a.size()), 16'h0000);
    chk_word(crc_o, exp_crc);
    for (int c = 0; c < 2; c++) begin
      chk_word(16'(done_cnt[c]), 16'(exp_done[c]));
      chk_word(16'(err_cnt[c]), 16'(exp_err[c]));
    end
  endtask : end_chk

  // Write and interrupt monitor, sampled at the rising edge
  always @(posedge clk_i) begin
    if (!sys_rst_i) begin
      for (int c = 0; c < 2; c++) begin
        done_cnt[c] += int'(done_irq_o[c]);
        err_cnt[c] += int'(err_irq_o[c]);
      end
      if (wr_req_o === 1'h1 && exp_a.size() == 0) chk_flag(2'h1, 2'h0);
      else if (wr_req_o === 1'h1) begin
        chk_word(wr_addr_o, exp_a.pop_front());
        chk_byte(wr_data_o, exp_d.pop_front());
      end
    end
  end

  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  // Main sequence: table rows first, then the awkward cases
  initial begin
    sys_rst_i <= 1'h1;
    ce_i <= 1'h1;
    {ch_en_i, sw_req_i, periph_req_i, event_i, crc_en_i} <= '0;
    {trig_sel_i, src_mode_i, dst_mode_i, src_reload_i, dst_reload_i, burst_sel_i} <= '0;
    {src_addr_i, dst_addr_i, block_size_i, repeat_i} <= '0;
    {link_en_i, prio_rr_i, crc_clr_i} <= '0;
    ee_map_en_i <= 1'h1;
    {done_ie_i, err_ie_i} <= 4'hF;
    // Memory, I/O and mapped EEPROM in several combinations
    rows[0] = '{1'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 16'h2100, 16'h2200, 16'h0006, 8'h01, 1'h1};
    rows[1] = '{1'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 16'h0040, 16'h2300, 16'h0008, 8'h02, 1'h0};
    rows[2] = '{1'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 16'h2405, 16'h0050, 16'h0003, 8'h01, 1'h0};
    rows[3] = '{1'h1, 2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h2, 16'h1010, 16'h2510, 16'h0004, 8'h02, 1'h1};
    rows[4] = '{1'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 16'h0070, 16'h0060, 16'h0005, 8'h03, 1'h0};
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(negedge clk_i);
    chk_word({7'h00, rd_req_o, wr_req_o, busy_o, done_irq_o, err_irq_o, active_ch_o}, 16'h0000);
    chk_word(rd_addr_o | wr_addr_o, 16'h0000);
    chk_word(crc_o, `CRC_INIT);
    fire(2'h1, dma_pkg::TR_SW);
    repeat (3) @(negedge clk_i);
    chk_flag(busy_o, 2'h0);
    foreach (rows[i]) begin
      cfg(rows[i]);
      build(rows[i]);
      fire(2'h1 << rows[i].c, (rows[i].trig == 2'h2) ? 2'h0 : rows[i].trig + 2'h1);
      @(negedge clk_i);
      chk_flag(busy_o, 2'h0);
      fire(2'h1 << rows[i].c, rows[i].trig);
      wait_idle(rows[i].c);
      exp_done[rows[i].c]++;
      end_chk();
    end
    // Unmapped EEPROM source: no access, error pulse only
    @(posedge clk_i);
    ee_map_en_i <= 1'h0;
    cfg(rows[3]);
    fire(2'h2, dma_pkg::TR_SW);
    wait_idle(1'h1);
    exp_err[1]++;
    end_chk();
    // Both armed at once under fixed priority; done interrupt masked on one
    ee_map_en_i <= 1'h1;
    done_ie_i <= 2'h1;
    er = rows[1];
    er.trig = dma_pkg::TR_EVENT;
    cfg(rows[2]);
    cfg(er);
    build(rows[2]);
    build(er);
    fire(2'h3, dma_pkg::TR_EVENT);
    wait_idle(1'h0);
    wait_idle(1'h1);
    exp_done[0]++;
    end_chk();
    chk_flag({1'h0, active_ch_o}, 2'h1);
    // Interlink: channel 1 follows channel 0; disabling stops the ping-pong
    link_en_i <= 1'h1;
    done_ie_i <= 2'h3;
    cfg(rows[2]);
    cfg(er);
    build(rows[2]);
    build(er);
    fire(2'h1, dma_pkg::TR_EVENT);
    wait_idle(1'h0);
    ch_en_i[0] <= 1'h0;
    wait_idle(1'h1);
    exp_done[0]++;
    exp_done[1]++;
    end_chk();
    // Round robin: single-byte bursts of channel 0 alternate with 8-byte bursts of channel 1
    link_en_i <= 1'h0;
    prio_rr_i <= 1'h1;
    cfg(rows[2]);
    cfg(er);
    er.rep = 8'h01;
    q = rows[2];
    q.blk = 16'h0001;
    for (int k = 0; k < 3; k++) begin
      build(q);
      q.src = q.src - 16'h0001;
      if (k < 2) build(er);
    end
    fire(2'h3, dma_pkg::TR_EVENT);
    wait_idle(1'h0);
    wait_idle(1'h1);
    exp_done[0]++;
    exp_done[1]++;
    end_chk();
    summarize();
  end
endmodule : two_channel_dma_engine_tb_top
